// ---- hw/fdst_consts.svh ----
// Constants of the drive self-test and status logic: offsets, fields and timing.
// Assumes inclusion by bare name from the package and the design modules.
// Summary of operation
// - At power-up, step carriage in off track zero, then back out, no diskette needed.
// - Inward step failure or track-zero stuck at one flashes three then two.
// - Outward step failure or track-zero stuck at zero flashes three then three.
// - On each lever close while idle, no index pulse within timeout flashes three then four.
// - A failed test repeats only after the lever is opened and closed again.
// - A close reruns it only after one whole error flash cycle ran with the lever open, or after a retest request.
// - Activity indicator lights whenever the host selects this drive and no error is flashing.
// - Write protected diskette disables write gate and raises write-protect status.
// - Index sensors decide single or double sided media, shown at the interface.
// - Address strap selects one of four drives; write and status outputs gated by select, head load is not.
// - Head is loaded while the lever is latched, unloaded otherwise.
// - Trim-erase control follows the gated write gate during writes.
`ifndef FDST_CONSTS_SVH
`define FDST_CONSTS_SVH
`define FDST_REG_CTRL 12'h000
`define FDST_REG_STAT 12'h004
`define FDST_REG_ERR 12'h008
`define FDST_CTRL_RESET 32'h0000_0000
`define FDST_CTRL_RETEST_BIT 0
`define FDST_FLASH_ON_CYCLES 24'h00_0010
`define FDST_FLASH_OFF_CYCLES 24'h00_0010
`define FDST_GROUP_GAP_CYCLES 24'h00_0040
`define FDST_STEP_CYCLES 24'h00_0008
`define FDST_INDEX_WAIT_CYCLES 24'h00_0100
`define FDST_STEPS_IN 8'h04
`define FDST_FIRST_GROUP 4'h3
`define FDST_CODE_IN 4'h2
`define FDST_CODE_OUT 4'h3
`define FDST_CODE_INDEX 4'h4
`endif

// ---- hw/fdst_pkg.sv ----
// Types shared by the drive self-test and status logic.
// Assumes the constants header sits beside it.
`include "fdst_consts.svh"
package fdst_pkg;
	typedef enum logic [1:0] {
		FDST_ERR_NONE,
		FDST_ERR_IN,
		FDST_ERR_OUT,
		FDST_ERR_INDEX
	} fdst_err_t;
endpackage

// ---- hw/fdst_flasher.sv ----
// Front indicator flasher: plays N1 flashes, a gap, N2 flashes, a gap, repeating.
// Assumes code is held steady while run is high.
`timescale 1ns/1ns
`default_nettype none
`include "fdst_consts.svh"
module fdst_flasher #(
	parameter logic [23:0] ON_CYCLES = `FDST_FLASH_ON_CYCLES,
	parameter logic [23:0] OFF_CYCLES = `FDST_FLASH_OFF_CYCLES,
	parameter logic [23:0] GAP_CYCLES = `FDST_GROUP_GAP_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [3:0] code,
	output logic led,
	output logic cycle_done
);
	logic [23:0] timer;
	logic [3:0] count;
	logic second;
	logic lit;
	logic in_gap;
	wire [3:0] target = second ? code : `FDST_FIRST_GROUP;
	wire timer_end = (timer == 24'h00_0000);
	wire last_flash = (count == target - 4'h1);
	// Pattern: first group, gap, second group, gap; cycle_done on each full pass.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer <= 24'h00_0000;
			count <= 4'h0;
			second <= 1'b0;
			lit <= 1'b0;
			in_gap <= 1'b0;
			cycle_done <= 1'b0;
		end else if (!run) begin
			timer <= 24'h00_0000;
			count <= 4'h0;
			second <= 1'b0;
			lit <= 1'b0;
			in_gap <= 1'b0;
			cycle_done <= 1'b0;
		end else begin
			cycle_done <= 1'b0;
			if (!timer_end) begin
				timer <= timer - 24'h00_0001;
			end else if (in_gap) begin
				in_gap <= 1'b0;
				lit <= 1'b1;
				timer <= ON_CYCLES - 24'h00_0001;
			end else if (lit) begin
				lit <= 1'b0;
				if (last_flash) begin
					in_gap <= 1'b1;
					count <= 4'h0;
					second <= !second;
					cycle_done <= second;
					timer <= GAP_CYCLES - 24'h00_0001;
				end else begin
					count <= count + 4'h1;
					timer <= OFF_CYCLES - 24'h00_0001;
				end
			end else begin
				lit <= 1'b1;
				timer <= ON_CYCLES - 24'h00_0001;
			end
		end
	end
	assign led = lit;
endmodule
`default_nettype wire

// ---- hw/fdst_apb.sv ----
// APB slave for the self-test block: control, status and error code registers.
// Assumes a single clock with the rest of the block; answers with zero wait states.
`timescale 1ns/1ns
`default_nettype none
`include "fdst_consts.svh"
module fdst_apb (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] stat_value,
	input wire logic [31:0] err_value,
	output logic retest_pulse
);
	wire access = psel && penable;
	wire hit_ctrl = (paddr == `FDST_REG_CTRL);
	wire hit_stat = (paddr == `FDST_REG_STAT);
	wire hit_err = (paddr == `FDST_REG_ERR);
	wire mapped = hit_ctrl || hit_stat || hit_err;
	wire [31:0] read_mux = hit_stat ? stat_value : (hit_err ? err_value : `FDST_CTRL_RESET);
	assign pready = 1'b1;
	assign pslverr = access && !mapped;
	// Writing the retest bit is a self-clearing request, so the register reads zero.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			retest_pulse <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			retest_pulse <= access && pwrite && hit_ctrl && pwdata[`FDST_CTRL_RETEST_BIT];
			if (psel && !penable && !pwrite) begin
				prdata <= mapped ? read_mux : 32'h0000_0000;
			end
		end
	end
endmodule
`default_nettype wire

// ---- hw/fdst_top.sv ----
// Drive self-test, indicator and interface status logic.
// Assumes synchronous sensor and host inputs, and an APB master for the registers.
`timescale 1ns/1ns
`default_nettype none
`include "fdst_consts.svh"
module fdst_top #(
	parameter logic [23:0] STEP_CYCLES = `FDST_STEP_CYCLES,
	parameter logic [23:0] INDEX_WAIT_CYCLES = `FDST_INDEX_WAIT_CYCLES,
	parameter logic [7:0] STEPS_IN = `FDST_STEPS_IN
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] drive_addr,
	input wire logic [3:0] drive_select_n,
	input wire logic host_write_gate_n,
	input wire logic track0,
	input wire logic lever_closed,
	input wire logic protect_tab,
	input wire logic index_side0,
	input wire logic index_side1,
	output logic step_pulse,
	output logic step_in,
	output logic head_load,
	output logic write_enable,
	output logic trim_erase,
	output logic write_protect_n,
	output logic two_sided_n,
	output logic selected,
	output logic front_led
);
	typedef enum logic [2:0] {
		FDST_ST_IN,
		FDST_ST_OUT,
		FDST_ST_WAIT_INDEX,
		FDST_ST_IDLE,
		FDST_ST_FAIL,
		FDST_ST_FAIL_OPEN
	} fdst_state_t;
	fdst_state_t state;
	fdst_pkg::fdst_err_t err;
	logic [23:0] timer;
	logic [7:0] steps;
	logic lever_q;
	logic dual_seen;
	logic flash_done;
	logic flash_led;
	logic retest;
	logic [3:0] code;
	logic [1:0] open_cycles;
	// Selection decode: this drive answers only to its own select line.
	assign selected = !drive_select_n[drive_addr];
	wire lever_close_evt = lever_closed && !lever_q;
	wire timer_end = (timer == 24'h00_0000);
	wire flashing = (state == FDST_ST_FAIL) || (state == FDST_ST_FAIL_OPEN);
	wire any_index = index_side0 || index_side1;
	assign code = (err == fdst_pkg::FDST_ERR_IN) ? `FDST_CODE_IN :
		((err == fdst_pkg::FDST_ERR_OUT) ? `FDST_CODE_OUT : `FDST_CODE_INDEX);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lever_q <= 1'b0;
		end else begin
			lever_q <= lever_closed;
		end
	end
	// Power-up sequence: step in off track zero, then back out to idle; index checks run on each later lever close while idle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= FDST_ST_IN;
			err <= fdst_pkg::FDST_ERR_NONE;
			timer <= 24'h00_0000;
			steps <= 8'h00;
			step_pulse <= 1'b0;
			step_in <= 1'b1;
			dual_seen <= 1'b0;
			open_cycles <= 2'h0;
		end else begin
			step_pulse <= 1'b0;
			unique case (state)
				FDST_ST_IN: begin
					step_in <= 1'b1;
					if (!timer_end) begin
						timer <= timer - 24'h00_0001;
					end else if (steps == STEPS_IN) begin
						// Still at track zero after stepping in.
						if (track0) begin
							err <= fdst_pkg::FDST_ERR_IN;
							state <= FDST_ST_FAIL;
						end else begin
							steps <= 8'h00;
							state <= FDST_ST_OUT;
						end
					end else begin
						step_pulse <= 1'b1;
						steps <= steps + 8'h01;
						timer <= STEP_CYCLES - 24'h00_0001;
					end
				end
				FDST_ST_OUT: begin
					step_in <= 1'b0;
					if (!timer_end) begin
						timer <= timer - 24'h00_0001;
					end else if (track0) begin
						steps <= 8'h00;
						state <= FDST_ST_IDLE;
					end else if (steps == STEPS_IN + STEPS_IN) begin
						// Track zero never reached stepping out.
						err <= fdst_pkg::FDST_ERR_OUT;
						state <= FDST_ST_FAIL;
					end else begin
						step_pulse <= 1'b1;
						steps <= steps + 8'h01;
						timer <= STEP_CYCLES - 24'h00_0001;
					end
				end
				FDST_ST_IDLE: begin
					if (lever_close_evt) begin
						dual_seen <= 1'b0;
						timer <= INDEX_WAIT_CYCLES - 24'h00_0001;
						state <= FDST_ST_WAIT_INDEX;
					end
				end
				FDST_ST_WAIT_INDEX: begin
					// Side-one index hole marks double-sided media.
					if (index_side1) begin
						dual_seen <= 1'b1;
					end
					if (!lever_closed) begin
						state <= FDST_ST_IDLE;
					end else if (any_index) begin
						state <= FDST_ST_IDLE;
					end else if (timer_end) begin
						err <= fdst_pkg::FDST_ERR_INDEX;
						state <= FDST_ST_FAIL;
					end else begin
						timer <= timer - 24'h00_0001;
					end
				end
				FDST_ST_FAIL: begin
					open_cycles <= 2'h0;
					if (!lever_closed) begin
						state <= FDST_ST_FAIL_OPEN;
					end
				end
				FDST_ST_FAIL_OPEN: begin
					// The first completion pulse may close a cycle that began with the lever shut,
					// so two pulses seen with the lever open prove one whole cycle ran open.
					if (!lever_closed) begin
						if (retest) begin
							open_cycles <= 2'h2;
						end else if (flash_done && (open_cycles != 2'h2)) begin
							open_cycles <= open_cycles + 2'h1;
						end
					end else if ((open_cycles == 2'h2) || retest) begin
						// Reopened and closed after a full cycle or a retest request: rerun the test.
						err <= fdst_pkg::FDST_ERR_NONE;
						steps <= 8'h00;
						open_cycles <= 2'h0;
						if (err == fdst_pkg::FDST_ERR_INDEX) begin
							dual_seen <= 1'b0;
							timer <= INDEX_WAIT_CYCLES - 24'h00_0001;
							state <= FDST_ST_WAIT_INDEX;
						end else begin
							timer <= 24'h00_0000;
							state <= FDST_ST_IN;
						end
					end else begin
						// Closed too early: keep indicating and wait for the next opening.
						state <= FDST_ST_FAIL;
					end
				end
				default: begin
					state <= FDST_ST_IDLE;
				end
			endcase
		end
	end
	fdst_flasher u_flasher (
		.pclk(pclk),
		.presetn(presetn),
		.run(flashing),
		.code(code),
		.led(flash_led),
		.cycle_done(flash_done)
	);
	// Error pattern wins over activity lighting.
	assign front_led = flashing ? flash_led : selected;
	// Head is loaded exactly while the lever is latched.
	assign head_load = lever_closed;
	// Write gate blocked by a protected diskette.
	assign write_enable = selected && !host_write_gate_n && !protect_tab && lever_closed;
	// Trim erase runs with the gated write.
	assign trim_erase = write_enable;
	assign write_protect_n = !(selected && protect_tab);
	assign two_sided_n = !(selected && dual_seen);
	wire [31:0] stat_value = {24'h00_0000, 1'b0, state, dual_seen, protect_tab, lever_closed, track0};
	wire [31:0] err_value = {28'h000_0000, code & {4{err != fdst_pkg::FDST_ERR_NONE}}};
	fdst_apb u_apb (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.stat_value(stat_value),
		.err_value(err_value),
		.retest_pulse(retest)
	);
	fdst_led_prio_a: assert property (@(posedge pclk) disable iff (!presetn)
		flashing |-> front_led == flash_led) else $error("error pattern lost to activity");
	fdst_act_led_a: assert property (@(posedge pclk) disable iff (!presetn)
		!flashing && selected |-> front_led) else $error("selected drive not lit");
	fdst_wr_prot_a: assert property (@(posedge pclk) disable iff (!presetn)
		protect_tab |-> !write_enable && !trim_erase) else $error("write while protected");
	fdst_head_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		head_load == lever_closed) else $error("head load mismatch");
	fdst_in_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == FDST_ST_IN && timer_end && steps == STEPS_IN && track0 |=> err == fdst_pkg::FDST_ERR_IN)
		else $error("inward failure not coded");
	fdst_out_ok_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == FDST_ST_OUT && timer_end && track0 |=> state == FDST_ST_IDLE) else $error("out test end");
	sequence fdst_fail_closed_s;
		state == FDST_ST_FAIL && lever_closed;
	endsequence
	fdst_hold_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
		fdst_fail_closed_s |=> flashing) else $error("error ended with lever closed");
	fdst_idx_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == FDST_ST_WAIT_INDEX && lever_closed && !any_index && timer_end |=> err == fdst_pkg::FDST_ERR_INDEX)
		else $error("missing index not coded");
	fdst_out_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == FDST_ST_OUT && timer_end && !track0 && steps == STEPS_IN + STEPS_IN |=> err == fdst_pkg::FDST_ERR_OUT)
		else $error("outward failure not coded");
	// Step pulses only come from the two carriage phases, each with its own direction.
	fdst_step_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(state == FDST_ST_IN || state == FDST_ST_OUT) |=> !step_pulse) else $error("stray step pulse");
	fdst_step_in_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
		step_pulse && state == FDST_ST_IN |-> step_in) else $error("inward step with outward direction");
	fdst_step_out_dir_a: assert property (@(posedge pclk) disable iff (!presetn)
		step_pulse && state == FDST_ST_OUT |-> !step_in) else $error("outward step with inward direction");
	fdst_idle_clean_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == FDST_ST_IDLE |-> err == fdst_pkg::FDST_ERR_NONE) else $error("idle with error pending");
	fdst_flash_err_a: assert property (@(posedge pclk) disable iff (!presetn)
		flashing |-> err != fdst_pkg::FDST_ERR_NONE) else $error("flashing without an error");
	fdst_led_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!flashing |=> !flash_led) else $error("flasher lit while no error");
	fdst_two_sided_a: assert property (@(posedge pclk) disable iff (!presetn)
		state == FDST_ST_WAIT_INDEX && index_side1 |=> dual_seen) else $error("side one index missed");
	fdst_sel_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		!selected |-> write_protect_n && two_sided_n && !write_enable) else $error("unselected drive drives status");
	fdst_trim_erase_a: assert property (@(posedge pclk) disable iff (!presetn)
		trim_erase == write_enable) else $error("trim erase not with write");
	// A close that comes before a full open cycle must fall back to waiting.
	sequence fdst_early_close_s;
		state == FDST_ST_FAIL_OPEN && lever_closed && open_cycles != 2'h2 && !retest;
	endsequence
	sequence fdst_open_wait_s;
		state == FDST_ST_FAIL_OPEN && !lever_closed;
	endsequence
	sequence fdst_reopen_s;
		state == FDST_ST_FAIL_OPEN && lever_closed && (open_cycles == 2'h2 || retest);
	endsequence
	fdst_early_close_a: assert property (@(posedge pclk) disable iff (!presetn)
		fdst_early_close_s |=> state == FDST_ST_FAIL) else $error("early close ended the error cycle");
	fdst_open_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		fdst_open_wait_s |=> flashing) else $error("error ended with lever open");
	fdst_retest_idx_a: assert property (@(posedge pclk) disable iff (!presetn)
		fdst_reopen_s ##0 err == fdst_pkg::FDST_ERR_INDEX |=> state == FDST_ST_WAIT_INDEX)
		else $error("index test not rerun");
endmodule
`default_nettype wire

// ---- testbench/fdst_mech_model.sv ----
// Carriage, track-zero sensor and index sensor model for the self-test bench.
// Assumes step requests arrive as one-cycle pulses on the design clock.
`timescale 1ns/1ns
`default_nettype none
module fdst_mech_model (
	input wire logic pclk,
	input wire logic step_pulse,
	input wire logic step_in,
	input wire logic lever_closed,
	input wire logic [1:0] mode,
	input wire logic disk,
	input wire logic two_sided,
	output logic track0,
	output logic index_side0,
	output logic index_side1
);
	int pos = 0;
	int tick = 0;
	logic jam;
	// Mode 1 jams inward motion and mode 2 jams outward motion, as a stuck band would.
	assign jam = step_in ? (mode == 2'd1) : (mode == 2'd2);
	assign track0 = (pos == 0);
	always @(posedge pclk) begin
		if (step_pulse && !jam) begin
			pos <= step_in ? pos + 1 : (pos > 0 ? pos - 1 : 0);
		end
		tick <= (lever_closed && disk) ? (tick + 1) % 40 : 0;
	end
	// No spinning diskette means no index hole, so both sensors stay dark.
	assign index_side0 = lever_closed && disk && (tick == 39);
	assign index_side1 = index_side0 && two_sided;
endmodule
`default_nettype wire

// ---- testbench/tb_drive_selftest_status_logic.sv ----
// Self-checking bench for the drive self-test and status block.
// Assumes the mechanics model stands in for carriage and sensors.
`timescale 1ns/1ns
`default_nettype none
module tb_drive_selftest_status_logic;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata;
	logic pready, pslverr, e;
	logic [1:0] drive_addr = 0;
	logic [1:0] mode = 0;
	logic [3:0] drive_select_n = 4'hf;
	logic host_write_gate_n = 1;
	logic lever_closed = 0;
	logic protect_tab = 0;
	logic disk = 0;
	logic two_sided = 0;
	logic track0, index_side0, index_side1, step_pulse, step_in, head_load;
	logic write_enable, trim_erase, write_protect_n, two_sided_n, selected, front_led;
	logic [31:0] rd;
	int err_total = 0;
	int tests_run = 0;
	int g1, g2;
	int n_in = 0;
	int n_out = 0;
	fdst_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drive_addr(drive_addr), .drive_select_n(drive_select_n),
		.host_write_gate_n(host_write_gate_n), .track0(track0), .lever_closed(lever_closed),
		.protect_tab(protect_tab), .index_side0(index_side0), .index_side1(index_side1),
		.step_pulse(step_pulse), .step_in(step_in), .head_load(head_load),
		.write_enable(write_enable), .trim_erase(trim_erase), .write_protect_n(write_protect_n),
		.two_sided_n(two_sided_n), .selected(selected), .front_led(front_led));
	fdst_mech_model u_mech (.pclk(pclk), .step_pulse(step_pulse), .step_in(step_in),
		.lever_closed(lever_closed), .mode(mode), .disk(disk), .two_sided(two_sided),
		.track0(track0), .index_side0(index_side0), .index_side1(index_side1));
	// Step pulses are counted by direction so the power-up sweep can be checked.
	always @(posedge pclk) begin
		if (step_pulse === 1'b1) begin
			if (step_in === 1'b1) n_in++;
			else n_out++;
		end
	end
	initial begin
		forever #5 pclk = ~pclk;
	end
	function logic sel_exp(logic [3:0] dsn, logic [1:0] a);
		return !dsn[a];
	endfunction
	function logic we_exp(logic p, logic g_n);
		return !p && !g_n;
	endfunction
	task chk(input logic [31:0] s, input logic [31:0] x);
		tests_run++;
		if (s !== x) begin
			err_total++;
			$display("Error at %0t: saw %h expected %h", $time, s, x);
		end
	endtask
	task results;
		$display("Counts: %0d compares, %0d mismatches", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task rst;
		@(posedge pclk);
		presetn <= 1'b0;
		wt(4);
		presetn <= 1'b1;
	endtask
	task rdr(input logic [11:0] a);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wrr(input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= 1'b1;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
	endtask
	// A group ends once the indicator has been dark for longer than any in-group pause.
	task grp(output int n);
		int low;
		logic p;
		n = 0;
		low = 0;
		p = 0;
		while (low < 40) begin
			@(negedge pclk);
			if (front_led === 1'b1) begin
				if (!p) n++;
				p = 1;
				low = 0;
			end else begin
				p = 0;
				low++;
			end
		end
	endtask
	task flashes(input int code);
		grp(g1);
		grp(g1);
		grp(g2);
		if (g1 != 3) begin
			g1 = g2;
			grp(g2);
		end
		chk(g1, 3);
		chk(g2, code);
	endtask
	task lever(input logic v, input int n);
		@(posedge pclk);
		lever_closed <= v;
		wt(n);
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		err_total++;
		results();
	end
	initial begin
		rd = $urandom(65);
		rst();
		wt(300);
		chk(n_in, 4);
		chk(n_out, 4);
		rdr(12'h008);
		chk(rd, 32'h0000_0000);
		rdr(12'h004);
		chk(rd[0], 1'b1);
		rdr(12'h00c);
		chk(e, 1'b1);
		chk(rd, 32'h0000_0000);
		$display("Done: power-up self-test");
		repeat (12) begin
			@(posedge pclk);
			drive_addr <= 2'($urandom);
			drive_select_n <= 4'($urandom);
			@(negedge pclk);
			chk(selected, sel_exp(drive_select_n, drive_addr));
			chk(front_led, sel_exp(drive_select_n, drive_addr));
		end
		$display("Done: drive select");
		@(posedge pclk);
		drive_select_n <= ~(4'h1 << drive_addr);
		disk <= 1'b1;
		two_sided <= 1'b1;
		lever(1'b1, 1);
		for (int i = 0; i < 4; i++) begin
			@(posedge pclk);
			protect_tab <= i[0];
			host_write_gate_n <= i[1];
			@(negedge pclk);
			chk(write_enable, we_exp(i[0], i[1]));
			chk(trim_erase, we_exp(i[0], i[1]));
			chk(write_protect_n, !i[0]);
			chk(head_load, 1'b1);
		end
		wt(300);
		chk(two_sided_n, 1'b0);
		rdr(12'h008);
		chk(rd, 32'h0000_0000);
		lever(1'b0, 0);
		two_sided <= 1'b0;
		@(negedge pclk);
		chk(head_load, 1'b0);
		lever(1'b1, 300);
		chk(two_sided_n, 1'b1);
		$display("Done: write path and media status");
		lever(1'b0, 5);
		disk <= 1'b0;
		lever(1'b1, 400);
		rdr(12'h008);
		chk(rd, 32'h0000_0004);
		flashes(4);
		@(posedge pclk);
		disk <= 1'b1;
		wt(400);
		rdr(12'h008);
		chk(rd, 32'h0000_0004);
		lever(1'b0, 10);
		lever(1'b1, 400);
		rdr(12'h008);
		chk(rd, 32'h0000_0004);
		lever(1'b0, 800);
		lever(1'b1, 400);
		rdr(12'h008);
		chk(rd, 32'h0000_0000);
		$display("Done: missing index");
		lever(1'b0, 5);
		disk <= 1'b0;
		lever(1'b1, 400);
		rdr(12'h008);
		chk(rd, 32'h0000_0004);
		lever(1'b0, 2);
		disk <= 1'b1;
		wrr(12'h000, 32'h0000_0001);
		chk(e, 1'b0);
		lever(1'b1, 300);
		rdr(12'h008);
		chk(rd, 32'h0000_0000);
		rdr(12'h000);
		chk(rd, 32'h0000_0000);
		$display("Done: retest request");
		drive_select_n <= 4'hf;
		lever(1'b0, 1);
		for (int m = 1; m < 3; m++) begin
			mode <= 2'(m);
			rst();
			wt(400);
			rdr(12'h008);
			chk(rd, 32'(m + 1));
			flashes(m + 1);
		end
		$display("Done: carriage faults");
		results();
	end
endmodule
`default_nettype wire
